// ===== design/tges_defs.svh
// Purpose: timing counts, reset values and encodings for the status block
// Assumes: user-interface clock of 20 MHz
// Notes: included by bare name
`ifndef TGES_DEFS_SVH
`define TGES_DEFS_SVH
`define TGES_CLK_MHZ 20
`define TGES_WDOG_US 100
`define TGES_WDOG_CYC (`TGES_WDOG_US * `TGES_CLK_MHZ)
`define TGES_REREAD_NUM 4
`define TGES_PTR_W 6
`define TGES_PTR_EXIT_BIT 5
`define TGES_ERR_WRITE 1'b0
`define TGES_ERR_READ 1'b1
`define TGES_FLAG_RST 1'b0
`endif

// ===== design/tges_pkg.sv
// Purpose: shared types for the status block
// Assumes: nothing
// Notes: constants live in tges_defs.svh
package tges_pkg;
  typedef enum logic [1:0] {
    SRC_DEFAULT,
    SRC_DIRECT,
    SRC_TABLE
  } tges_src_t;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RUN,
    ST_REREAD_ISSUE,
    ST_REREAD_WAIT,
    ST_HALT,
    ST_DONE
  } tges_state_t;
endpackage

// ===== design/tges_watchdog.sv
// Purpose: timeout on missing command accept or read return
// Assumes: activity pulses from same clock
// Notes: flag holds until a clear pulse
`timescale 1ns/10ps
`include "tges_defs.svh"
module tges_watchdog #(
  parameter int TIMEOUT = `TGES_WDOG_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic armed,
  input wire logic activity,
  input wire logic clearHang,
  output logic hang
);
  localparam int CW = $clog2(TIMEOUT + 1);
  logic [CW-1:0] cnt_ff;
  logic hang_ff;
  if (TIMEOUT < 1) begin
    $error("timeout must be at least one cycle");
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_ff <= '0;
    end else if (ce) begin
      if (!armed || activity || clearHang) begin
        cnt_ff <= '0;
      end else if (cnt_ff != CW'(TIMEOUT)) begin
        cnt_ff <= cnt_ff + CW'(1);
      end
    end
  end
  // set wins over clear so a late timeout is not lost
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hang_ff <= `TGES_FLAG_RST;
    end else if (ce) begin
      if (armed && !activity && cnt_ff == CW'(TIMEOUT - 1)) begin
        hang_ff <= 1'b1;
      end else if (clearHang) begin
        hang_ff <= 1'b0;
      end
    end
  end
  assign hang = hang_ff;
endmodule

// ===== design/tges_reread.sv
// Purpose: classify first fault by repeated reads of the failing address
// Assumes: one read data word per issued read, in order
// Notes: start is a one-cycle pulse
`timescale 1ns/10ps
`include "tges_defs.svh"
module tges_reread #(
  parameter int DW = 32,
  parameter int NREAD = `TGES_REREAD_NUM
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic start,
  input wire logic [DW-1:0] firstBad,
  input wire logic cmdTaken,
  input wire logic rdValid,
  input wire logic [DW-1:0] rdData,
  output logic issue,
  output logic finished,
  output logic kind
);
  localparam int NW = $clog2(NREAD + 1);
  logic [NW-1:0] sent_ff;
  logic [NW-1:0] got_ff;
  logic busy_ff;
  logic diff_ff;
  logic finished_ff;
  if (NREAD < 1) begin
    $error("need at least one re-read");
  end
  assign issue = busy_ff && (sent_ff != NW'(NREAD));
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      busy_ff <= 1'b0;
      sent_ff <= '0;
      got_ff <= '0;
      diff_ff <= 1'b0;
      finished_ff <= 1'b0;
    end else if (ce) begin
      finished_ff <= 1'b0;
      if (start) begin
        busy_ff <= 1'b1;
        sent_ff <= '0;
        got_ff <= '0;
        diff_ff <= 1'b0;
      end else if (busy_ff) begin
        if (issue && cmdTaken) begin
          sent_ff <= sent_ff + NW'(1);
        end
        if (rdValid) begin
          got_ff <= got_ff + NW'(1);
          if (rdData != firstBad) begin
            diff_ff <= 1'b1;
          end
          if (got_ff == NW'(NREAD - 1)) begin
            busy_ff <= 1'b0;
            finished_ff <= 1'b1;
          end
        end
      end
    end
  end
  // same wrong value every time means it was stored wrong
  assign kind = diff_ff ? `TGES_ERR_READ : `TGES_ERR_WRITE;
  assign finished = finished_ff;
endmodule

// ===== design/tges_status.sv
// Purpose: status, error classification and source select of traffic gen
// Assumes: all inputs on the user-interface clock
// Notes: pattern generation lives elsewhere; this tracks and steers it
// Contract
// - error kind means something only while its valid bit is 1.
// - error kind is 0 for write error, 1 for read error.
// - completion flag rises once all programmed instructions finish.
// - endless instruction loops never raise the completion flag.
// - write-read mode instruction finishing pulses write-phase-done.
// - hang flag sets when commands or read data stall past timeout.
// - accumulated mismatch flag holds once any mismatch is seen.
// - clear, continue or restart trigger clears accumulated mismatch.
// - three instruction sources: default memory, direct, table.
// - direct enable takes all instruction fields from direct inputs.
// - with checking on, first mismatch triggers several re-reads.
// - all re-reads same wrong value means write error.
// - any re-read differing from first wrong value means read error.
// - first mismatch pattern and address are captured and held.
// - checking on halts after first error; off keeps running.
// - pointer with top bit of six set is exit; 0-31 valid.
`timescale 1ns/10ps
`include "tges_defs.svh"
module tges_status #(
  parameter int DW = 32,
  parameter int AW = 28,
  parameter int IW = 64,
  parameter int TIMEOUT = `TGES_WDOG_CYC,
  parameter int NREAD = `TGES_REREAD_NUM
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic clearErrorsTrigger,
  input wire logic resumeAfterErrorTrigger,
  input wire logic trafficRestartTrigger,
  input wire logic errorKindCheckEnable,
  input wire logic directInstructionEnable,
  input wire logic tableSelect,
  input wire logic [IW-1:0] directInstruction,
  input wire logic [`TGES_PTR_W-1:0] directNextPointer,
  input wire logic [IW-1:0] defaultInstruction,
  input wire logic [`TGES_PTR_W-1:0] defaultNextPointer,
  input wire logic [IW-1:0] tableInstruction,
  input wire logic [`TGES_PTR_W-1:0] tableNextPointer,
  input wire logic instrStart,
  input wire logic instrEnd,
  input wire logic instrWriteRead,
  input wire logic cmdIssue,
  input wire logic cmdAccepted,
  input wire logic rdDataValid,
  input wire logic [DW-1:0] rdData,
  input wire logic [DW-1:0] expData,
  input wire logic [AW-1:0] rdAddr,
  output logic [IW-1:0] activeInstruction,
  output logic [`TGES_PTR_W-1:0] activeSlot,
  output logic trafficRun,
  output logic rereadIssue,
  output logic [AW-1:0] rereadAddr,
  output logic errorKindResult,
  output logic errorKindValid,
  output logic trafficCompleteFlag,
  output logic writePhaseDonePulse,
  output logic hangDetectFlag,
  output logic accumulatedMismatchFlag,
  output logic firstMismatchValid,
  output logic [DW-1:0] firstMismatchPattern,
  output logic [AW-1:0] firstMismatchLocation,
  output logic mismatchValid,
  output logic [DW-1:0] mismatchPattern,
  output logic [AW-1:0] mismatchLocation
);
  tges_pkg::tges_state_t state_ff;
  tges_pkg::tges_src_t src;
  logic [`TGES_PTR_W-1:0] slot_ff;
  logic [`TGES_PTR_W-1:0] nextPtr;
  logic [DW-1:0] firstRead_ff;
  logic firstValid_ff;
  logic [DW-1:0] firstPat_ff;
  logic [AW-1:0] firstAddr_ff;
  logic accum_ff;
  logic kind_ff;
  logic kindValid_ff;
  logic done_ff;
  logic wrDone_ff;
  logic errValid_ff;
  logic [DW-1:0] errPat_ff;
  logic [AW-1:0] errAddr_ff;
  logic clearAll;
  logic mismatch;
  logic rrStart;
  logic rrFinished;
  logic rrKind;
  logic rrCmdTaken;
  logic rrValid;
  logic wdArmed;
  logic wdActivity;
  logic rrIssue;
  logic wdClear;

  // reject widths the capture registers cannot hold
  if (DW < 1 || AW < 1 || IW < 1) begin
    $error("widths must be positive");
  end
  if (TIMEOUT < 1 || NREAD < 1) begin
    $error("timeout and re-read count must be positive");
  end
  if (`TGES_PTR_EXIT_BIT >= `TGES_PTR_W) begin
    $error("exit bit outside the pointer");
  end

  function automatic logic isExit(input logic [`TGES_PTR_W-1:0] p);
    return p[`TGES_PTR_EXIT_BIT];
  endfunction

  assign clearAll = clearErrorsTrigger || resumeAfterErrorTrigger ||
    trafficRestartTrigger;
  assign mismatch = rdDataValid && (rdData != expData) &&
    state_ff == tges_pkg::ST_RUN;

  // source choice: direct wins, then table, else default memory
  always_comb begin
    if (directInstructionEnable) begin
      src = tges_pkg::SRC_DIRECT;
    end else if (tableSelect) begin
      src = tges_pkg::SRC_TABLE;
    end else begin
      src = tges_pkg::SRC_DEFAULT;
    end
  end

  always_comb begin
    case (src)
      tges_pkg::SRC_DIRECT: begin
        activeInstruction = directInstruction;
        nextPtr = directNextPointer;
      end
      tges_pkg::SRC_TABLE: begin
        activeInstruction = tableInstruction;
        nextPtr = tableNextPointer;
      end
      default: begin
        activeInstruction = defaultInstruction;
        nextPtr = defaultNextPointer;
      end
    endcase
  end
  assign activeSlot = slot_ff;
  assign trafficRun = state_ff == tges_pkg::ST_RUN;

  // main sequencing
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_ff <= tges_pkg::ST_IDLE;
      slot_ff <= '0;
    end else if (ce) begin
      case (state_ff)
        tges_pkg::ST_IDLE: begin
          if (instrStart) begin
            state_ff <= tges_pkg::ST_RUN;
          end
        end
        tges_pkg::ST_RUN: begin
          if (mismatch && errorKindCheckEnable && !firstValid_ff) begin
            state_ff <= tges_pkg::ST_REREAD_ISSUE;
          end else if (instrEnd) begin
            if (isExit(nextPtr)) begin
              state_ff <= tges_pkg::ST_DONE;
            end else begin
              // looping pointers never reach done
              slot_ff <= nextPtr;
            end
          end
        end
        tges_pkg::ST_REREAD_ISSUE: begin
          state_ff <= tges_pkg::ST_REREAD_WAIT;
        end
        tges_pkg::ST_REREAD_WAIT: begin
          if (rrFinished) begin
            state_ff <= tges_pkg::ST_HALT;
          end
        end
        tges_pkg::ST_HALT: begin
          if (resumeAfterErrorTrigger) begin
            state_ff <= tges_pkg::ST_RUN;
          end
        end
        tges_pkg::ST_DONE: begin
          state_ff <= tges_pkg::ST_DONE;
        end
        default: begin
          state_ff <= tges_pkg::ST_IDLE;
        end
      endcase
      if (trafficRestartTrigger) begin
        state_ff <= tges_pkg::ST_IDLE;
        slot_ff <= '0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      done_ff <= `TGES_FLAG_RST;
    end else if (ce) begin
      if (trafficRestartTrigger) begin
        done_ff <= 1'b0;
      end else if (state_ff == tges_pkg::ST_RUN && instrEnd &&
          isExit(nextPtr)) begin
        done_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wrDone_ff <= 1'b0;
    end else if (ce) begin
      // registered pulse, cleared the next cycle
      wrDone_ff <= instrEnd && instrWriteRead &&
        state_ff == tges_pkg::ST_RUN;
    end
  end

  // first error capture, set wins over clear
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      firstValid_ff <= `TGES_FLAG_RST;
      firstPat_ff <= '0;
      firstAddr_ff <= '0;
      firstRead_ff <= '0;
    end else if (ce) begin
      if (mismatch && !firstValid_ff) begin
        firstValid_ff <= 1'b1;
        firstPat_ff <= rdData ^ expData;
        firstAddr_ff <= rdAddr;
        firstRead_ff <= rdData;
      end else if (clearAll) begin
        firstValid_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      accum_ff <= `TGES_FLAG_RST;
    end else if (ce) begin
      if (mismatch) begin
        accum_ff <= 1'b1;
      end else if (clearAll) begin
        accum_ff <= 1'b0;
      end
    end
  end

  // running mismatch report, mainly useful with checking off
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      errValid_ff <= 1'b0;
      errPat_ff <= '0;
      errAddr_ff <= '0;
    end else if (ce) begin
      errValid_ff <= mismatch;
      if (mismatch) begin
        errPat_ff <= rdData ^ expData;
        errAddr_ff <= rdAddr;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      kindValid_ff <= `TGES_FLAG_RST;
      kind_ff <= `TGES_ERR_WRITE;
    end else if (ce) begin
      if (rrFinished) begin
        kindValid_ff <= 1'b1;
        kind_ff <= rrKind;
      end else if (clearAll) begin
        kindValid_ff <= 1'b0;
      end
    end
  end

  assign rrStart = state_ff == tges_pkg::ST_REREAD_ISSUE;
  assign rrCmdTaken = cmdAccepted && state_ff == tges_pkg::ST_REREAD_WAIT;
  assign rrValid = rdDataValid && state_ff == tges_pkg::ST_REREAD_WAIT;

  tges_reread #(
    .DW(DW),
    .NREAD(NREAD)
  ) uReread (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .start(rrStart),
    .firstBad(firstRead_ff),
    .cmdTaken(rrCmdTaken),
    .rdValid(rrValid),
    .rdData(rdData),
    .issue(rrIssue),
    .finished(rrFinished),
    .kind(rrKind)
  );
  assign rereadAddr = firstAddr_ff;
  // gated by state so a restart mid-classify stops stray re-reads
  assign rereadIssue = rrIssue &&
    state_ff == tges_pkg::ST_REREAD_WAIT;

  // armed only while traffic or re-reads are in flight
  assign wdArmed = state_ff == tges_pkg::ST_RUN ||
    state_ff == tges_pkg::ST_REREAD_WAIT;
  assign wdActivity = cmdAccepted || rdDataValid || !(cmdIssue ||
    rereadIssue || state_ff == tges_pkg::ST_REREAD_WAIT);

  // continue leaves hang set so a stalled controller stays visible
  assign wdClear = clearErrorsTrigger || trafficRestartTrigger;
  tges_watchdog #(
    .TIMEOUT(TIMEOUT)
  ) uWatchdog (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .armed(wdArmed),
    .activity(wdActivity),
    .clearHang(wdClear),
    .hang(hangDetectFlag)
  );

  assign errorKindResult = kind_ff;
  assign errorKindValid = kindValid_ff;
  assign trafficCompleteFlag = done_ff;
  assign writePhaseDonePulse = wrDone_ff;
  assign accumulatedMismatchFlag = accum_ff;
  assign firstMismatchValid = firstValid_ff;
  assign firstMismatchPattern = firstPat_ff;
  assign firstMismatchLocation = firstAddr_ff;
  assign mismatchValid = errValid_ff;
  assign mismatchPattern = errPat_ff;
  assign mismatchLocation = errAddr_ff;
endmodule

// ===== sim/tges_status_assertions.sv
// Purpose: concurrent checks on the status block ports
// Assumes: clock enable held high by the bench
// Notes: bound from the bench top file
`timescale 1ns/10ps
module tges_status_assertions #(
  parameter int DW = 32,
  parameter int AW = 28,
  parameter int TIMEOUT = 2000
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clearErrorsTrigger,
  input wire logic resumeAfterErrorTrigger,
  input wire logic trafficRestartTrigger,
  input wire logic errorKindCheckEnable,
  input wire logic instrEnd,
  input wire logic instrWriteRead,
  input wire logic cmdAccepted,
  input wire logic rdDataValid,
  input wire logic [DW-1:0] rdData,
  input wire logic [DW-1:0] expData,
  input wire logic [AW-1:0] rdAddr,
  input wire logic trafficRun,
  input wire logic rereadIssue,
  input wire logic [AW-1:0] rereadAddr,
  input wire logic errorKindValid,
  input wire logic writePhaseDonePulse,
  input wire logic hangDetectFlag,
  input wire logic accumulatedMismatchFlag,
  input wire logic firstMismatchValid,
  input wire logic [DW-1:0] firstMismatchPattern,
  input wire logic [AW-1:0] firstMismatchLocation
);
  logic [15:0] quiet_ff;
  logic anyClr;
  assign anyClr = clearErrorsTrigger | resumeAfterErrorTrigger |
    trafficRestartTrigger;
  // saturates so a long stall cannot wrap back to a small count
  always_ff @(posedge clk) begin
    if (!reset_n || cmdAccepted || rdDataValid) begin
      quiet_ff <= 16'h0000;
    end else if (quiet_ff != 16'hFFFF) begin
      quiet_ff <= quiet_ff + 16'h0001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_bad;
    rdDataValid && rdData != expData && trafficRun;
  endsequence
  sequence s_first;
    $rose(firstMismatchValid) && errorKindCheckEnable;
  endsequence
  property p_wr_cause;
    writePhaseDonePulse |-> $past(instrEnd) && $past(instrWriteRead);
  endproperty
  property p_wr_once;
    writePhaseDonePulse && !instrEnd |=> !writePhaseDonePulse;
  endproperty
  property p_acc_set;
    s_bad |=> accumulatedMismatchFlag;
  endproperty
  property p_acc_hold;
    accumulatedMismatchFlag && !anyClr |=> accumulatedMismatchFlag;
  endproperty
  property p_acc_clr;
    anyClr && !rdDataValid |=> !accumulatedMismatchFlag;
  endproperty
  property p_first_cap;
    s_bad ##0 !firstMismatchValid |=> firstMismatchValid &&
      firstMismatchPattern == ($past(rdData) ^ $past(expData)) &&
      firstMismatchLocation == $past(rdAddr);
  endproperty
  property p_first_hold;
    firstMismatchValid && !anyClr |=> $stable(firstMismatchPattern) &&
      $stable(firstMismatchLocation) && firstMismatchValid;
  endproperty
  property p_reread;
    s_first |-> ##[0:2] (rereadIssue && rereadAddr == firstMismatchLocation);
  endproperty
  property p_halt;
    errorKindValid && errorKindCheckEnable |-> !trafficRun;
  endproperty
  property p_kind_valid;
    $rose(errorKindValid) |-> firstMismatchValid && errorKindCheckEnable;
  endproperty
  property p_hang_rise;
    $rose(hangDetectFlag) |-> quiet_ff >= TIMEOUT - 2;
  endproperty
  property p_hang_hold;
    hangDetectFlag && !clearErrorsTrigger && !trafficRestartTrigger |=>
      hangDetectFlag;
  endproperty
  a_wr_cause: assert property (p_wr_cause)
    else $error("write-phase pulse without cause");
  a_wr_once: assert property (p_wr_once)
    else $error("write-phase pulse too long");
  a_acc_set: assert property (p_acc_set)
    else $error("mismatch not accumulated");
  a_acc_hold: assert property (p_acc_hold)
    else $error("accumulated flag dropped");
  a_acc_clr: assert property (p_acc_clr)
    else $error("accumulated flag not cleared");
  a_first_cap: assert property (p_first_cap)
    else $error("first mismatch capture wrong");
  a_first_hold: assert property (p_first_hold)
    else $error("first mismatch overwritten");
  a_reread: assert property (p_reread)
    else $error("no re-read of failing address");
  a_halt: assert property (p_halt)
    else $error("traffic runs after classified fault");
  a_kind_valid: assert property (p_kind_valid)
    else $error("kind valid without first mismatch");
  a_hang_rise: assert property (p_hang_rise)
    else $error("hang flag raised early");
  a_hang_hold: assert property (p_hang_hold)
    else $error("hang flag dropped");
endmodule

// ===== sim/tges_mem_model.sv
// Purpose: memory user-interface stand-in for the status bench
// Assumes: one read word per accepted command, fixed latency
// Notes: mode 1 repeats one corruption, mode 2 changes it after the first
`timescale 1ns/10ps
module tges_mem_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cmdIssue,
  input wire logic rereadIssue,
  input wire logic stall,
  input wire logic [1:0] mode,
  input wire logic [31:0] good,
  output logic cmdAccepted,
  output logic rdDataValid,
  output logic [31:0] rdData
);
  logic [2:0] pend_ff;
  logic bad_ff;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cmdAccepted <= 1'b0;
      rdDataValid <= 1'b0;
      pend_ff <= 3'h0;
      bad_ff <= 1'b0;
      rdData <= 32'h5A5A5A5A;
    end else begin
      // at best every other cycle, like a busy controller
      cmdAccepted <= (cmdIssue | rereadIssue) & ~stall & ~cmdAccepted;
      pend_ff <= {pend_ff[1:0], cmdAccepted};
      rdDataValid <= pend_ff[2];
      bad_ff <= (mode != 2'h0) & (bad_ff | pend_ff[2]);
      // idle bus toggles so stale data never looks valid
      if (!pend_ff[2]) begin
        rdData <= ~rdData;
      end else if (mode == 2'h0) begin
        rdData <= good;
      end else if (mode == 2'h2 && bad_ff) begin
        rdData <= good ^ 32'h60;
      end else begin
        rdData <= good ^ 32'h100;
      end
    end
  end
endmodule

// ===== sim/tges_status_bench.sv
// Purpose: self-checking bench for the traffic generator status block
// Assumes: memory interface stand-in in tges_mem_model
// Notes: watchdog shortened to 20 cycles to keep the run short
`timescale 1ns/10ps
module tges_status_bench;
  localparam int TO = 20;
  integer seed = 93;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int nRep = 0;
  logic [63:0] q[$];
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  logic clrT = 1'b0, resT = 1'b0, rstT = 1'b0, iStart = 1'b0, iEnd = 1'b0;
  logic chkEn = 1'b0, dirEn = 1'b0, tblSel = 1'b0, iWr = 1'b0;
  logic cmdIssue = 1'b0, stall = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [63:0] dIns, fIns, tIns, act;
  logic [5:0] dPtr = 6'h00, fPtr = 6'h00, tPtr = 6'h00, slot;
  logic [31:0] good, rdData, fPat, errPat;
  logic [27:0] addr, fLoc, errLoc;
  logic cmdAccepted, rdDataValid, rereadIssue, run, kind, kindV;
  logic done, wrDone, hang, accum, firstV, errV;
  logic firstVd = 1'b0, kindVd = 1'b0;
  tges_status #(.TIMEOUT(TO)) i_dut (.clk(clk), .reset_n(reset_n), .ce(ce),
    .clearErrorsTrigger(clrT), .resumeAfterErrorTrigger(resT),
    .trafficRestartTrigger(rstT), .errorKindCheckEnable(chkEn),
    .directInstructionEnable(dirEn), .tableSelect(tblSel),
    .directInstruction(dIns), .directNextPointer(dPtr),
    .defaultInstruction(fIns), .defaultNextPointer(fPtr),
    .tableInstruction(tIns), .tableNextPointer(tPtr), .instrStart(iStart),
    .instrEnd(iEnd), .instrWriteRead(iWr), .cmdIssue(cmdIssue),
    .cmdAccepted(cmdAccepted), .rdDataValid(rdDataValid), .rdData(rdData),
    .expData(good), .rdAddr(addr), .activeInstruction(act), .activeSlot(slot),
    .trafficRun(run), .rereadIssue(rereadIssue), .rereadAddr(),
    .errorKindResult(kind), .errorKindValid(kindV),
    .trafficCompleteFlag(done), .writePhaseDonePulse(wrDone),
    .hangDetectFlag(hang), .accumulatedMismatchFlag(accum),
    .firstMismatchValid(firstV), .firstMismatchPattern(fPat),
    .firstMismatchLocation(fLoc), .mismatchValid(errV),
    .mismatchPattern(errPat), .mismatchLocation(errLoc));
  tges_mem_model i_mem (.clk(clk), .reset_n(reset_n), .cmdIssue(cmdIssue),
    .rereadIssue(rereadIssue), .stall(stall), .mode(mode), .good(good),
    .cmdAccepted(cmdAccepted), .rdDataValid(rdDataValid), .rdData(rdData));
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic endt(input string n);
    $display("test %s finished at %0t", n, $time);
  endtask
  // triggers as {restart, resume, clear, end, start}
  task automatic hit(input logic [4:0] m);
    @(posedge clk);
    {rstT, resT, clrT, iEnd, iStart} <= m;
    @(posedge clk);
    {rstT, resT, clrT, iEnd, iStart} <= 5'h00;
    @(posedge clk);
  endtask
  task automatic wait_hi(ref logic s);
    for (int i = 0; i < 200 && s !== 1'b1; i++) begin
      @(posedge clk);
    end
  endtask
  task automatic rd_cmd;
    @(posedge clk);
    cmdIssue <= 1'b1;
    wait_hi(cmdAccepted);
    cmdIssue <= 1'b0;
  endtask
  function automatic logic [63:0] note();
    return q.size() > 0 ? q.pop_front() : 64'hX;
  endfunction
  always @(posedge clk) begin
    firstVd <= firstV;
    kindVd <= kindV;
    if (reset_n) begin
      if (wrDone !== 1'b0) check(wrDone, note());
      if (firstV && !firstVd) check({fLoc, fPat}, note());
      if (kindV && !kindVd) check(kind, note());
      if (errV !== 1'b0) begin
        nRep++;
        check({errLoc, errPat}, {4'h0, addr, 32'h00000100});
      end
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      finish_test();
    end
  end
  initial begin
    good = $random(seed);
    addr = 28'($random(seed));
    dIns = {$random(seed), $random(seed)};
    fIns = {$random(seed), $random(seed)};
    tIns = {$random(seed), $random(seed)};
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    check({kindV, done, wrDone, hang, accum, firstV}, 64'h0);
    for (int s = 0; s < 3; s++) begin
      @(posedge clk);
      {dirEn, tblSel} <= s == 0 ? 2'h0 : s == 1 ? 2'h3 : 2'h1;
      @(posedge clk);
      @(posedge clk);
      check(act, s == 0 ? fIns : s == 1 ? dIns : tIns);
    end
    endt("sources");
    @(posedge clk);
    {dirEn, iWr} <= 2'h3;
    hit(5'h01);
    dPtr <= {1'b0, 5'($random(seed))};
    q.push_back(64'h1);
    hit(5'h02);
    check(done, 1'b0);
    check(slot, dPtr);
    dPtr <= {1'b1, 5'($random(seed))};
    q.push_back(64'h1);
    hit(5'h02);
    check(done, 1'b1);
    hit(5'h10);
    check(done, 1'b0);
    endt("completion");
    hit(5'h01);
    mode <= 2'h1;
    cmdIssue <= 1'b1;
    q.push_back({4'h0, addr, 32'h00000100});
    repeat (30) @(posedge clk);
    check(run, 1'b1);
    cmdIssue <= 1'b0;
    repeat (6) @(posedge clk);
    check(accum, 1'b1);
    check(nRep > 1, 1'b1);
    hit(5'h04);
    check({accum, firstV}, 64'h0);
    endt("continuous compare");
    chkEn <= 1'b1;
    for (int k = 1; k < 3; k++) begin
      mode <= 2'h0;
      hit(5'h10);
      hit(5'h01);
      mode <= 2'(k);
      q.push_back({4'h0, addr, 32'h00000100});
      q.push_back(64'(k == 2));
      rd_cmd();
      wait_hi(kindV);
      check(run, 1'b0);
      hit(k == 1 ? 5'h08 : 5'h04);
      check({accum, kindV, run}, 64'(k == 1));
    end
    endt("fault classify");
    mode <= 2'h0;
    hit(5'h10);
    hit(5'h01);
    stall <= 1'b1;
    cmdIssue <= 1'b1;
    wait_hi(hang);
    check(hang, 1'b1);
    hit(5'h08);
    check(hang, 1'b1);
    stall <= 1'b0;
    cmdIssue <= 1'b0;
    hit(5'h04);
    check(hang, 1'b0);
    endt("watchdog");
    check(q.size(), 64'h0);
    finish_test();
  end
endmodule
bind tges_status tges_status_assertions #(.DW(DW), .AW(AW),
  .TIMEOUT(TIMEOUT)) u_chk (.clk(clk), .reset_n(reset_n),
  .clearErrorsTrigger(clearErrorsTrigger),
  .resumeAfterErrorTrigger(resumeAfterErrorTrigger),
  .trafficRestartTrigger(trafficRestartTrigger),
  .errorKindCheckEnable(errorKindCheckEnable), .instrEnd(instrEnd),
  .instrWriteRead(instrWriteRead), .cmdAccepted(cmdAccepted),
  .rdDataValid(rdDataValid), .rdData(rdData), .expData(expData),
  .rdAddr(rdAddr), .trafficRun(trafficRun), .rereadIssue(rereadIssue),
  .rereadAddr(rereadAddr), .errorKindValid(errorKindValid),
  .writePhaseDonePulse(writePhaseDonePulse),
  .hangDetectFlag(hangDetectFlag),
  .accumulatedMismatchFlag(accumulatedMismatchFlag),
  .firstMismatchValid(firstMismatchValid),
  .firstMismatchPattern(firstMismatchPattern),
  .firstMismatchLocation(firstMismatchLocation));
